// [hdl/flash_status_write_protect.sv]
// status register, write gating and program/erase protection check
module flash_status_write_protect (
  input wire logic sys_clk, // system clock, 20 MHz
  input wire logic resetn, // sync reset = power cycle, active low
  input wire logic cmd_valid, // one-cycle decoded instruction strobe
  input wire logic [7:0] cmd_op, // instruction code
  input wire logic [15:0] cmd_wdata, // status write data, S15..S0
  input wire logic wp_pin, // write-protect pin level
  input wire logic pe_valid, // program/erase request strobe
  input wire logic [flash_prot_pkg::ADDR_W-1:0] pe_addr, // target address
  input wire logic pe_done, // program/erase finished
  output logic pe_go, // request allowed, one-cycle pulse
  output logic pe_refused, // request refused, one-cycle pulse
  output logic [7:0] rd_data, // status byte for read instruction
  output logic rd_valid, // rd_data valid pulse
  output logic four_lane_enable, // pins act as data lanes
  output logic wp_pin_active // pin acts as write-protect
);
  logic write_enable_latch_reg; // latch state
  logic paused_op_flag_reg; // suspend flag
  logic [2:0] bp; // block protect bits
  logic top_bottom_select; // range end
  logic small_unit_select; // granularity
  logic [1:0] lock_mode; // {hi, lo}
  logic qe; // four lane field
  logic [3:0] otp_lock; // security register locks
  logic invert_protection; // complement
  logic sr_wr_ok; // status write accepted
  logic lock_allows; // lock mode permits write
  logic win_hit; // address in uninverted window
  logic [15:0] status_word; // whole status view

  // lock mode gating of status writes
  always_comb begin
    case (lock_mode)
      flash_prot_pkg::LOCK_SOFT: lock_allows = 1'b1;
      flash_prot_pkg::LOCK_HW: lock_allows = wp_pin_active ? wp_pin : 1'b1;
      flash_prot_pkg::LOCK_POWER: lock_allows = 1'b0;
      flash_prot_pkg::LOCK_OTP: lock_allows = 1'b0;
      default: lock_allows = 1'b0;
    endcase
  end
  // pin only counts while it is not a data lane
  assign sr_wr_ok = cmd_valid && (cmd_op == flash_prot_pkg::OP_WRSR) &&
    write_enable_latch_reg && lock_allows;

  // plain fields; reset models power cycle so lock 10 returns to 00
  flash_status_bits #(.W(3), .STICKY(1'b0)) u_bp (
    .sys_clk(sys_clk), .resetn(resetn), .wr_en(sr_wr_ok),
    .wr_data(cmd_wdata[flash_prot_pkg::BIT_BP_HI:flash_prot_pkg::BIT_BP_LO]),
    .q(bp)
  );
  flash_status_bits #(.W(2), .STICKY(1'b0)) u_sel (
    .sys_clk(sys_clk), .resetn(resetn), .wr_en(sr_wr_ok),
    .wr_data({cmd_wdata[flash_prot_pkg::BIT_SEC], cmd_wdata[flash_prot_pkg::BIT_TB]}),
    .q({small_unit_select, top_bottom_select})
  );
  flash_status_bits #(.W(2), .STICKY(1'b0)) u_lock (
    .sys_clk(sys_clk), .resetn(resetn), .wr_en(sr_wr_ok),
    .wr_data(cmd_wdata[flash_prot_pkg::BIT_LOCK_HI:flash_prot_pkg::BIT_LOCK_LO]),
    .q(lock_mode)
  );
  flash_status_bits #(.W(2), .STICKY(1'b0)) u_qe_cmp (
    .sys_clk(sys_clk), .resetn(resetn), .wr_en(sr_wr_ok),
    .wr_data({cmd_wdata[flash_prot_pkg::BIT_CMP], cmd_wdata[flash_prot_pkg::BIT_QE]}),
    .q({invert_protection, qe})
  );
  // one-time bits: or-in, never cleared except by reset
  flash_status_bits #(.W(4), .STICKY(1'b1)) u_otp (
    .sys_clk(sys_clk), .resetn(resetn), .wr_en(sr_wr_ok),
    .wr_data(cmd_wdata[flash_prot_pkg::BIT_OTP_HI:flash_prot_pkg::BIT_OTP_LO]),
    .q(otp_lock)
  );

  // write enable latch; cleared by disable, status write, finished op
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      write_enable_latch_reg <= 1'b0;
    end else if (cmd_valid && cmd_op == flash_prot_pkg::OP_WREN) begin
      write_enable_latch_reg <= 1'b1;
    end else if ((cmd_valid && (cmd_op == flash_prot_pkg::OP_WRDI ||
                 cmd_op == flash_prot_pkg::OP_WRSR)) || pe_done) begin
      write_enable_latch_reg <= 1'b0;
    end
  end

  // suspend flag: set wins, only one opcode per strobe anyway
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      paused_op_flag_reg <= 1'b0;
    end else if (cmd_valid && cmd_op == flash_prot_pkg::OP_SUSPEND) begin
      paused_op_flag_reg <= 1'b1;
    end else if (cmd_valid && cmd_op == flash_prot_pkg::OP_RESUME) begin
      paused_op_flag_reg <= 1'b0;
    end
  end

  // range decode of the target address
  flash_range_decode u_dec (
    .bp(bp),
    .tb(top_bottom_select),
    .sec(small_unit_select),
    .addr(pe_addr),
    .hit(win_hit)
  );

  // protection verdict; invert flips the window exactly
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pe_go <= 1'b0;
      pe_refused <= 1'b0;
    end else begin
      pe_go <= pe_valid && write_enable_latch_reg &&
        !(win_hit ^ invert_protection);
      pe_refused <= pe_valid && (!write_enable_latch_reg ||
        (win_hit ^ invert_protection));
    end
  end

  assign status_word = {paused_op_flag_reg, invert_protection, otp_lock, qe, lock_mode,
    small_unit_select, top_bottom_select, bp, write_enable_latch_reg, 1'b0};

  // status reads; busy bit is outside this block and reads zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cmd_valid && (cmd_op == flash_prot_pkg::OP_RDSR_LO ||
        cmd_op == flash_prot_pkg::OP_RDSR_HI);
      if (cmd_valid && cmd_op == flash_prot_pkg::OP_RDSR_HI) begin
        rd_data <= status_word[15:8];
      end else if (cmd_valid && cmd_op == flash_prot_pkg::OP_RDSR_LO) begin
        rd_data <= status_word[7:0];
      end
    end
  end

  // pin function select registered for clean outputs
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      four_lane_enable <= 1'b0;
      wp_pin_active <= 1'b1;
    end else begin
      four_lane_enable <= qe;
      wp_pin_active <= !qe;
    end
  end
endmodule : flash_status_write_protect

// [hdl/flash_prot_pkg.sv]
// Function
// - three-bit block protect field in bits four..two
// - block protect resets to zero, nothing guarded
// - refuse program and erase in protected range
// - top select zero guards top, one guards bottom
// - granularity one counts 4KB, zero counts 64KB
// - invert bit fourteen swaps protected and unprotected
// - two lock mode bits at eight and seven
// - mode 00 ignores pin, needs write enable latch
// - mode 01 with pin low rejects writes unless four-lane enable is set
// - mode 01 with pin high needs latch
// - mode 10 locks until power cycle, then 00
// - mode 11 locks status register, but reset returns it to 00 as for mode 10
// - suspend flag set by 75h, cleared by 7Ah
// - one-time lock bits only ever set
// - four-lane enable turns pins into data lanes
// - code 000 guards nothing, 111 guards all
// - 64KB doubling to 2MB from top or bottom
// - 4KB, 8KB, 16KB, 32KB at either end
// - inversion guards exact complement of range
// - write enable latch set by write enable
package flash_prot_pkg;
  localparam int ADDR_W = 22; // 4MB array
  localparam logic [7:0] OP_WREN = 8'h06; // write enable
  localparam logic [7:0] OP_WRDI = 8'h04; // write disable
  localparam logic [7:0] OP_WRSR = 8'h01; // write status
  localparam logic [7:0] OP_RDSR_LO = 8'h05; // read status low
  localparam logic [7:0] OP_RDSR_HI = 8'h35; // read status high
  localparam logic [7:0] OP_SUSPEND = 8'h75; // pause program/erase
  localparam logic [7:0] OP_RESUME = 8'h7a; // resume program/erase
  // status bit positions across both bytes
  localparam int BIT_WEL = 1;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_BP_HI = 4;
  localparam int BIT_TB = 5;
  localparam int BIT_SEC = 6;
  localparam int BIT_LOCK_LO = 7;
  localparam int BIT_LOCK_HI = 8;
  localparam int BIT_QE = 9;
  localparam int BIT_OTP_LO = 10;
  localparam int BIT_OTP_HI = 13;
  localparam int BIT_CMP = 14;
  localparam int BIT_SUS = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000; // factory state
  localparam logic [2:0] BP_NONE = 3'h0; // no protection code
  localparam logic [2:0] BP_ALL = 3'h7; // whole array code
  localparam int BLOCK_SHIFT = 16; // 64KB units
  localparam int SECTOR_SHIFT = 12; // 4KB units
  localparam logic [1:0] LOCK_SOFT = 2'h0;
  localparam logic [1:0] LOCK_HW = 2'h1;
  localparam logic [1:0] LOCK_POWER = 2'h2;
  localparam logic [1:0] LOCK_OTP = 2'h3;
endpackage : flash_prot_pkg

// [hdl/flash_status_bits.sv]
// one run of status bits with a shared write gate and sticky option
module flash_status_bits #(
  parameter int W = 1, // field width
  parameter bit STICKY = 1'b0 // bits only ever set once written
) (
  input wire logic sys_clk, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic wr_en, // accepted status write
  input wire logic [W-1:0] wr_data, // new field value
  output logic [W-1:0] q // field value
);
  // sticky fields or-in so a written one never drops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
    end else if (wr_en) begin
      q <= STICKY ? (q | wr_data) : wr_data;
    end
  end
endmodule : flash_status_bits

// [hdl/flash_range_decode.sv]
// combinational decode of the guarded window, lo..hi inclusive
module flash_range_decode (
  input wire logic [2:0] bp, // block protect code
  input wire logic tb, // top/bottom select
  input wire logic sec, // small unit select
  input wire logic [flash_prot_pkg::ADDR_W-1:0] addr, // target address
  output logic hit // address lies in guarded region
);
  logic [flash_prot_pkg::ADDR_W:0] span; // size of window in bytes
  logic in_win; // inside uninverted window
  always_comb begin
    span = '0;
    if (bp == flash_prot_pkg::BP_ALL) begin
      span = (flash_prot_pkg::ADDR_W+1)'(1) << flash_prot_pkg::ADDR_W;
    end else if (bp == flash_prot_pkg::BP_NONE) begin
      span = '0;
    end else if (sec) begin
      // 10x caps at 32KB; bp0 is a don't care there
      span = (flash_prot_pkg::ADDR_W+1)'(1) <<
        (flash_prot_pkg::SECTOR_SHIFT + (bp[2] ? 3 : int'(bp) - 1));
    end else begin
      span = (flash_prot_pkg::ADDR_W+1)'(1) <<
        (flash_prot_pkg::BLOCK_SHIFT + int'(bp) - 1);
    end
    // top: addr >= size-span; bottom: addr < span
    if (tb) begin
      in_win = {1'b0, addr} < span;
    end else begin
      in_win = ({1'b0, addr} + span) >= ((flash_prot_pkg::ADDR_W+1)'(1)
        << flash_prot_pkg::ADDR_W);
    end
  end
  assign hit = in_win;
endmodule : flash_range_decode

// [verification/flash_status_write_protect_properties.sv]
// port-level checks of the status/protect block
module flash_status_write_protect_properties (
  input wire logic sys_clk, // clock
  input wire logic resetn, // sync reset, active low
  input wire logic cmd_valid, // instruction strobe
  input wire logic [7:0] cmd_op, // instruction code
  input wire logic pe_valid, // program/erase strobe
  input wire logic pe_go, // request allowed
  input wire logic pe_refused, // request refused
  input wire logic [7:0] rd_data, // status byte
  input wire logic rd_valid, // read pulse
  input wire logic four_lane_enable, // pins are lanes
  input wire logic wp_pin_active // pin is write-protect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic rd_cmd; // a status read taken this cycle
  assign rd_cmd = cmd_valid && (cmd_op == flash_prot_pkg::OP_RDSR_LO ||
    cmd_op == flash_prot_pkg::OP_RDSR_HI);
  property p_answer; pe_valid |=> pe_go ^ pe_refused; endproperty
  a_answer: assert property (p_answer) else $error("pe answer missing");
  property p_quiet; !pe_valid |=> !pe_go && !pe_refused; endproperty
  a_quiet: assert property (p_quiet) else $error("pe answer unasked");
  property p_excl; pe_go |-> !pe_refused; endproperty
  a_excl: assert property (p_excl) else $error("pe both answers");
  property p_rd; rd_cmd |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rd_quiet; !rd_cmd |=> !rd_valid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read unasked");
  property p_rd_hold; $changed(rd_data) |-> rd_valid; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_lanes; four_lane_enable ^ wp_pin_active; endproperty
  a_lanes: assert property (p_lanes) else $error("pin role clash");
  // a disable leaves the latch clear, so the next request must bounce
  property p_wrdi; cmd_valid && cmd_op == flash_prot_pkg::OP_WRDI ##1 !cmd_valid
    ##1 pe_valid |=> pe_refused; endproperty
  a_wrdi: assert property (p_wrdi) else $error("pe allowed after disable");
  c_go: cover property (pe_go);
  c_ref: cover property (pe_refused);
  c_lanes: cover property ($rose(four_lane_enable));
endmodule : flash_status_write_protect_properties

bind flash_status_write_protect flash_status_write_protect_properties u_props (
  .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .pe_valid(pe_valid), .pe_go(pe_go), .pe_refused(pe_refused), .rd_data(rd_data),
  .rd_valid(rd_valid), .four_lane_enable(four_lane_enable), .wp_pin_active(wp_pin_active));

// [verification/flash_host_model.sv]
// host side: issues decoded instructions and program/erase requests
module flash_host_model (
  input wire logic sys_clk, // system clock
  output logic cmd_valid = 1'b0, // instruction strobe
  output logic [7:0] cmd_op = 8'h00, // instruction code
  output logic [15:0] cmd_wdata = 16'h0000, // status write data
  output logic pe_valid = 1'b0, // program/erase strobe
  output logic [flash_prot_pkg::ADDR_W-1:0] pe_addr = '0 // target address
);
  timeunit 1ns;
  timeprecision 1ps;
  // one instruction; strobe and code held for a single taking edge
  task automatic cmd(input logic [7:0] op, input logic [15:0] d);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_op <= ~op; // released lines carry junk, not the old value
    cmd_wdata <= ~d;
  endtask : cmd
  // one program/erase request, held for its taking edge
  task automatic pe(input logic [flash_prot_pkg::ADDR_W-1:0] a);
    @(posedge sys_clk);
    pe_valid <= 1'b1;
    pe_addr <= a;
    @(posedge sys_clk);
    pe_valid <= 1'b0;
    pe_addr <= ~a;
  endtask : pe
endmodule : flash_host_model

// [verification/tb_flash_status_write_protect.sv]
module tb_flash_status_write_protect;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn = 1'b0, wp_pin = 1'b0, pe_done = 1'b0; // bench inputs
  logic cmd_valid, pe_valid, pe_go, pe_refused, rd_valid, four_lane_enable, wp_pin_active;
  logic [7:0] cmd_op, rd_data;
  logic [15:0] cmd_wdata;
  logic [flash_prot_pkg::ADDR_W-1:0] pe_addr;
  int fail_count = 0;
  int checks = 0;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
  flash_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_wdata(cmd_wdata), .pe_valid(pe_valid), .pe_addr(pe_addr));
  flash_status_write_protect dut (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .wp_pin(wp_pin), .pe_valid(pe_valid),
    .pe_addr(pe_addr), .pe_done(pe_done), .pe_go(pe_go), .pe_refused(pe_refused),
    .rd_data(rd_data), .rd_valid(rd_valid), .four_lane_enable(four_lane_enable),
    .wp_pin_active(wp_pin_active));
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // power cycle, reset held six edges
  task automatic pwr;
    @(posedge sys_clk) resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : pwr
  task automatic rd(input logic [7:0] op, input logic [7:0] e);
    host.cmd(op, 16'h0000);
    #1;
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask : rd
  task automatic wr(input logic [15:0] d);
    host.cmd(flash_prot_pkg::OP_WREN, 16'h0000);
    host.cmd(flash_prot_pkg::OP_WRSR, d);
  endtask : wr
  // latch set, then one request; answer is refusal exactly when guarded
  task automatic pg(input logic [flash_prot_pkg::ADDR_W-1:0] a, input logic p);
    host.cmd(flash_prot_pkg::OP_WREN, 16'h0000);
    host.pe(a);
    #1;
    `CHK(pe_refused, p)
    `CHK(pe_go, !p)
  endtask : pg
  task automatic t_reset;
    rd(flash_prot_pkg::OP_RDSR_LO, 8'h00);
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h00);
    `CHK({four_lane_enable, wp_pin_active}, 2'h1)
  endtask : t_reset
  // edges of sample windows, both ends, both units, inverted
  task automatic t_range;
    logic [15:0] s [14] = '{16'h0000, 16'h001c, 16'h0004, 16'h0004, 16'h0038, 16'h0038,
      16'h0044, 16'h0044, 16'h0074, 16'h0074, 16'h4004, 16'h4000, 16'h401c, 16'h004c};
    logic [21:0] a [14] = '{22'h3f_ffff, 22'h00_0000, 22'h3f_0000, 22'h3e_ffff, 22'h1f_ffff,
      22'h20_0000, 22'h3f_f000, 22'h3f_efff, 22'h00_7fff, 22'h00_8000, 22'h3e_ffff,
      22'h00_0000, 22'h3f_ffff, 22'h3f_c000};
    logic [13:0] p = 14'h2d56; // one bit per entry, entry 0 in bit 0
    for (int i = 0; i < 14; i++) begin
      wr(s[i]);
      rd(flash_prot_pkg::OP_RDSR_LO, s[i][7:0]);
      rd(flash_prot_pkg::OP_RDSR_HI, s[i][15:8]);
      pg(a[i], p[i]);
    end
  endtask : t_range
  // each lock mode; latch absent in mode 00, pin low and high in mode 01
  task automatic t_lock;
    wr(16'h0000);
    host.cmd(flash_prot_pkg::OP_WRSR, 16'h001c);
    rd(flash_prot_pkg::OP_RDSR_LO, 8'h00);
    wr(16'h0080);
    wr(16'h0084);
    rd(flash_prot_pkg::OP_RDSR_LO, 8'h80);
    @(posedge sys_clk) wp_pin <= 1'b1;
    wr(16'h0084);
    rd(flash_prot_pkg::OP_RDSR_LO, 8'h84);
    host.cmd(flash_prot_pkg::OP_WREN, 16'h0000);
    host.cmd(flash_prot_pkg::OP_WRDI, 16'h0000);
    host.pe(22'h00_0000);
    #1 `CHK(pe_refused, 1'b1)
    wr(16'h0100);
    wr(16'h0000);
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h01);
    pwr();
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h00);
    wr(16'h0180);
    wr(16'h0000);
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h01);
    rd(flash_prot_pkg::OP_RDSR_LO, 8'h80);
    pwr();
  endtask : t_lock
  // lock bits only accumulate; pin role follows the lane bit one edge later
  task automatic t_otp;
    wr(16'h0600);
    @(posedge sys_clk) #1 `CHK({four_lane_enable, wp_pin_active}, 2'h2)
    // pin is a data lane now, so hardware lock mode must not see it low
    @(posedge sys_clk) wp_pin <= 1'b0;
    wr(16'h0680);
    wr(16'h0684);
    rd(flash_prot_pkg::OP_RDSR_LO, 8'h84);
    wr(16'h0800);
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h0c);
    `CHK({four_lane_enable, wp_pin_active}, 2'h1)
    pwr();
  endtask : t_otp
  // suspend flag, and latch dropped by a finished operation
  task automatic t_sus;
    host.cmd(flash_prot_pkg::OP_SUSPEND, 16'h0000);
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h80);
    host.cmd(flash_prot_pkg::OP_RESUME, 16'h0000);
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h00);
    host.cmd(flash_prot_pkg::OP_SUSPEND, 16'h0000);
    pwr();
    rd(flash_prot_pkg::OP_RDSR_HI, 8'h00);
    host.cmd(flash_prot_pkg::OP_WREN, 16'h0000);
    @(posedge sys_clk) pe_done <= 1'b1;
    @(posedge sys_clk) pe_done <= 1'b0;
    host.pe(22'h00_0000);
    #1 `CHK(pe_refused, 1'b1)
  endtask : t_sus
  task automatic close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    pwr();
    t_reset();
    t_range();
    t_lock();
    t_otp();
    t_sus();
    close_out();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    close_out();
  end
endmodule : tb_flash_status_write_protect
